/* bench/ats_autotune_sequencer_assertions.sv */
// Port-level checks for the autotune sequencer
`default_nettype none
module ats_checker (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic sensor_break,
  input wire logic heat_on,
  input wire logic cool_on,
  input wire logic output_frozen,
  input wire logic tune_busy,
  input wire logic tune_fail
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Bus handshake
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  // Sequencing of the tune
  settle_off_a: assert property ($rose(tune_busy) |-> (!heat_on && !cool_on) [*8])
    else $error("output driven during settle");
  break_abort_a: assert property (sensor_break && tune_busy |-> ##[1:2] !tune_busy)
    else $error("tune not aborted on break");
  no_restart_a: assert property (sensor_break && !tune_busy |=> !tune_busy)
    else $error("tune started during break");
  frozen_busy_a: assert property (output_frozen |-> tune_busy)
    else $error("freeze outside tune");
  frozen_hold_a: assert property (output_frozen && $past(output_frozen) |->
    $stable(heat_on) && $stable(cool_on)) else $error("output moved while frozen");
  fail_sticky_a: assert property ($fell(tune_fail) |->
    $past(wb_we_i && wb_stb_i) || $past(wb_we_i && wb_stb_i, 2))
    else $error("failure flag cleared without write");
endmodule // ats_checker
bind ats_autotune_sequencer ats_checker i_chk (.mclk(mclk), .rstn(rstn), .clk_en(clk_en),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
  .sensor_break(sensor_break), .heat_on(heat_on), .cool_on(cool_on),
  .output_frozen(output_frozen), .tune_busy(tune_busy), .tune_fail(tune_fail));
`default_nettype wire

/* bench/ats_autotune_sequencer_bench.sv */
// Self-checking bench for the autotune sequencer
`default_nettype none
module ats_autotune_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, brk = 1'b0, load = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wdat = 32'h0, rdat, lo, rd_o;
  logic [15:0] pv, load_val = 16'h0100;
  logic        ack, heat, cool, frozen, busy, fail;
  int          error_cnt = 0;
  int          num_checks = 0;

  // 250 MHz clock
  always #2 mclk = ~mclk;

  ats_autotune_sequencer #(.CLK_HZ(10), .SETTLE_S(3)) i_dut (.mclk(mclk), .rstn(rstn),
    .clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rd_o), .wb_ack_o(ack),
    .measured_value(pv), .sensor_break(brk), .heat_on(heat), .cool_on(cool),
    .output_frozen(frozen), .tune_busy(busy), .tune_fail(fail));
  ats_plant i_plant (.mclk(mclk), .load(load), .load_val(load_val), .heat_on(heat),
    .cool_on(cool), .measured_value(pv));

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic single cycle: hold until ack is sampled, then release for a cycle
  task automatic xfer(input logic w, input logic [3:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) chk("ack", 32'h0, 32'h1);
  endtask

  task automatic rd(input logic [3:0] idx, input logic [31:0] exp, input string what);
    xfer(1'b0, idx, 32'h0);
    chk(what, rdat, exp);
  endtask

  // One tune from a preset plant value, with the outputs expected just after B
  task automatic run(input logic [31:0] ctrl, input logic [15:0] pv0, input logic [15:0] rcg,
                     input logic [1:0] hc, input logic frz);
    int n;
    @(posedge mclk);
    load <= 1'b1;
    load_val <= pv0;
    @(posedge mclk);
    load <= 1'b0;
    xfer(1'b1, 4'hC, {16'h0, rcg});
    xfer(1'b1, 4'h0, ctrl);
    xfer(1'b1, 4'h0, ctrl | 32'h1);
    repeat (5) @(posedge mclk);
    chk("frozen", frozen, frz);
    chk("busy", busy, 1'b1);
    repeat (45) @(posedge mclk);
    if (!frz) chk("outputs at B", {heat, cool}, hc);
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    chk("tune end", busy, 1'b0);
    xfer(1'b0, 4'h6, 32'h0);
    chk("low cutback floor", rdat * 10 >= 32'h40 * 16, 1'b1);
    xfer(1'b0, 4'h7, 32'h0);
    chk("high cutback floor", rdat * 10 >= 32'h40 * 16, 1'b1);
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    rd(4'h1, 32'h0, "status");
    rd(4'h8, 32'h100, "gain at reset");
    rd(4'hD, 32'h0, "unmapped");
    xfer(1'b1, 4'hB, 32'h1234);
    rd(4'hB, 32'h0, "read-only point");
    xfer(1'b1, 4'h2, 32'h500);
    xfer(1'b1, 4'h3, 32'h1000);
    xfer(1'b1, 4'h4, 32'h0);
    xfer(1'b1, 4'h5, 32'h40);
    run(32'h0, 16'h0100, 16'h0020, 2'b10, 1'b0);
    rd(4'hB, 32'h400, "tune point");
    rd(4'h8, 32'h100, "heat-only gain");
    xfer(1'b0, 4'h6, 32'h0);
    lo = rdat;
    rd(4'h7, lo, "high equals low");
    run(32'h0, 16'h0600, 16'h0020, 2'b00, 1'b0);
    xfer(1'b0, 4'h7, 32'h0);
    lo = rdat;
    rd(4'h6, lo, "low equals high");
    run(32'h2, 16'h0600, 16'h0B00, 2'b01, 1'b0);
    chk("fail raised", fail, 1'b1);
    rd(4'h8, 32'hA00, "clamped gain");
    run(32'h2, 16'h0100, 16'h0020, 2'b10, 1'b0);
    chk("fail cleared", fail, 1'b0);
    rd(4'h8, 32'h20, "cool gain");
    run(32'h2, 16'h0500, 16'h0020, 2'b00, 1'b1);
    // Sensor break mid-tune, then no restart without a new rising start
    xfer(1'b1, 4'h0, 32'h0);
    xfer(1'b1, 4'h0, 32'h1);
    repeat (60) @(posedge mclk);
    brk <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("abort", busy, 1'b0);
    brk <= 1'b0;
    xfer(1'b1, 4'h0, 32'h1);
    repeat (10) @(posedge mclk);
    chk("no restart", busy, 1'b0);
    xfer(1'b1, 4'h0, 32'h0);
    xfer(1'b1, 4'h0, 32'h1);
    repeat (3) @(posedge mclk);
    chk("restart", busy, 1'b1);
    print_verdict;
  end

  // Watchdog sized well beyond six tunes
  initial begin
    #300000;
    error_cnt++;
    print_verdict;
  end
endmodule // ats_autotune_sequencer_bench
`default_nettype wire

/* bench/ats_plant.sv */
// Behavioural heated and cooled plant with its sensor
`default_nettype none
module ats_plant #(
  parameter logic [15:0] AMBIENT = 16'h0100
) (
  input  wire logic        mclk,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic        heat_on,
  input  wire logic        cool_on,
  output var  logic [15:0] measured_value = 16'h0100
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] loss_cnt = 4'h0;
  // Drive moves one unit a cycle; natural loss is slow so a settle sees a steady value
  always @(posedge mclk) begin
    loss_cnt <= loss_cnt + 4'h1;
    if (load)
      measured_value <= load_val;
    else if (heat_on)
      measured_value <= measured_value + 16'h0001;
    else if (cool_on && measured_value != 16'h0000)
      measured_value <= measured_value - 16'h0001;
    else if (loss_cnt == 4'hF && measured_value > AMBIENT)
      measured_value <= measured_value - 16'h0001;
  end
endmodule // ats_plant
`default_nettype wire

/* design/ats_autotune_sequencer.v */
// Autotune sequencer with classic Wishbone register slave
`include "ats_map.vh"
`default_nettype none
module ats_autotune_sequencer #(
  parameter integer CLK_HZ = 250000000,
  parameter integer SETTLE_S = 60
) (
  input  wire        mclk,
  input  wire        rstn,
  input  wire        clk_en,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [15:0] measured_value,
  input  wire        sensor_break,
  output reg         heat_on,
  output reg         cool_on,
  output reg         output_frozen,
  output wire        tune_busy,
  output reg         tune_fail
);
  // Phase codes
  localparam [3:0] S_IDLE = 4'h0, S_FREEZE = 4'h1, S_SETTLE = 4'h2, S_OSC_HI = 4'h3,
                   S_OSC_LO = 4'h4, S_EXTRA = 4'h5, S_NAT = 4'h6, S_DONE = 4'h7;
  localparam [7:0]  SETTLE = SETTLE_S[7:0];

  reg [3:0]  state_reg;
  reg [15:0] ctrl_reg, sp_reg, rhi_reg, rlo_reg, pb_reg, rcg_in_reg;
  reg [15:0] low_cutback_reg, high_cutback_reg, rcg_reg, tcp_reg, init_reg;
  reg [15:0] per_reg, p2p_reg, pk_hi_reg, pk_lo_reg, secs_reg, ovs_reg;
  reg [31:0] div_reg;
  reg [7:0]  sec_cnt_reg;
  reg [1:0]  cyc_reg;
  reg        above_reg, atsp_reg, first_reg, start_q_reg;
  wire       tick = (div_reg == CLK_HZ - 1);
  wire [15:0] range = rhi_reg - rlo_reg;
  wire [31:0] tol_pct = ({16'h0000, range} * `ATS_TOL_PCT_NUM) / `ATS_TOL_PCT_DEN;
  wire [15:0] tol = ctrl_reg[`ATS_C_ENG] ? `ATS_TOL_ENG : tol_pct[15:0];
  wire [15:0] diff = (measured_value > sp_reg) ? measured_value - sp_reg
                                               : sp_reg - measured_value;
  wire        at_sp = (diff <= tol);
  // Rounded up so a floored cutback is never below 1.6 times the band
  wire [31:0] cb_min32 = ({16'h0000, pb_reg} * `ATS_CB_MIN_NUM + (`ATS_CB_MIN_DEN - 32'd1))
                         / `ATS_CB_MIN_DEN;
  wire [15:0] cb_min = cb_min32[15:0];
  wire        cool_en = ctrl_reg[`ATS_C_COOL];
  wire        start_req = ctrl_reg[`ATS_C_START] & ~start_q_reg;

  // Floor a cutback at 1.6 times the band
  function [15:0] cb_floor;
    input [15:0] v;
    input [15:0] m;
    begin
      cb_floor = (v < m) ? m : v;
    end
  endfunction

  // Tune control point: init + 0.75(sp - init) = (init + 3 sp) / 4
  function [15:0] tune_point;
    input [15:0] ini;
    input [15:0] sp;
    reg [17:0] s;
    begin
      s = {2'b00, ini} + {2'b00, sp} * 18'd3;
      tune_point = s[17:2];
    end
  endfunction

  assign tune_busy = (state_reg != S_IDLE);

  // Seconds tick; the phase timer in the sequencer restarts only on entry to S_FREEZE, S_SETTLE and S_NAT
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 32'h00000000;
    end else if (clk_en) begin
      div_reg <= tick ? 32'h00000000 : div_reg + 32'h00000001;
    end
  end

  // Sequencer
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= S_IDLE;
      sec_cnt_reg <= 8'h00;
      heat_on     <= 1'b0;
      cool_on     <= 1'b0;
      output_frozen <= 1'b0;
      tune_fail   <= 1'b0;
      init_reg    <= 16'h0000;
      tcp_reg     <= 16'h0000;
      low_cutback_reg    <= 16'h0000;
      high_cutback_reg    <= 16'h0000;
      rcg_reg     <= `ATS_RCG_ONE;
      per_reg     <= 16'h0000;
      p2p_reg     <= 16'h0000;
      pk_hi_reg   <= 16'h0000;
      pk_lo_reg   <= 16'hFFFF;
      secs_reg    <= 16'h0000;
      ovs_reg     <= 16'h0000;
      cyc_reg     <= 2'b00;
      above_reg   <= 1'b0;
      atsp_reg    <= 1'b0;
      first_reg   <= 1'b0;
      start_q_reg <= 1'b0;
    end else if (clk_en) begin
      start_q_reg <= ctrl_reg[`ATS_C_START];
      if (tick && sec_cnt_reg != 8'hFF)
        sec_cnt_reg <= sec_cnt_reg + 8'h01;
      if (tick)
        secs_reg <= secs_reg + 16'h0001;
      if (measured_value > pk_hi_reg)
        pk_hi_reg <= measured_value;
      if (measured_value < pk_lo_reg)
        pk_lo_reg <= measured_value;
      if (sensor_break && state_reg != S_IDLE) begin
        state_reg <= S_IDLE;
        heat_on   <= 1'b0;
        cool_on   <= 1'b0;
        output_frozen <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            if (start_req && !sensor_break) begin
              tune_fail   <= 1'b0;
              sec_cnt_reg <= 8'h00;
              above_reg   <= measured_value > sp_reg;
              if (at_sp) begin
                state_reg     <= S_FREEZE;
                output_frozen <= 1'b1;
              end else begin
                state_reg <= S_SETTLE;
                heat_on   <= 1'b0;
                cool_on   <= 1'b0;
              end
            end
          end
          S_FREEZE: begin
            // Output held at its present value by the loop while frozen
            if (!at_sp) begin
              state_reg     <= S_SETTLE;
              above_reg     <= measured_value > sp_reg;
              output_frozen <= 1'b0;
              heat_on       <= 1'b0;
              cool_on       <= 1'b0;
              sec_cnt_reg   <= 8'h00;
            end else if (sec_cnt_reg >= SETTLE) begin
              atsp_reg      <= 1'b1;
              output_frozen <= 1'b0;
              tcp_reg       <= sp_reg;
              cyc_reg       <= 2'b00;
              first_reg     <= 1'b1;
              pk_hi_reg     <= measured_value;
              pk_lo_reg     <= measured_value;
              secs_reg      <= 16'h0000;
              state_reg     <= S_OSC_HI;
              heat_on       <= 1'b1;
            end
          end
          S_SETTLE: begin
            if (sec_cnt_reg >= SETTLE) begin
              atsp_reg  <= 1'b0;
              init_reg  <= measured_value;
              tcp_reg   <= tune_point(measured_value, sp_reg);
              cyc_reg   <= 2'b00;
              first_reg <= 1'b1;
              pk_hi_reg <= measured_value;
              pk_lo_reg <= measured_value;
              secs_reg  <= 16'h0000;
              if (above_reg) begin
                state_reg <= S_OSC_LO;
                cool_on   <= cool_en;
              end else begin
                state_reg <= S_OSC_HI;
                heat_on   <= 1'b1;
              end
            end
          end
          S_OSC_HI: begin
            if (measured_value >= tcp_reg) begin
              state_reg <= S_OSC_LO;
              heat_on   <= 1'b0;
              cool_on   <= cool_en;
            end
          end
          S_OSC_LO: begin
            if (first_reg && !above_reg && !atsp_reg)
              ovs_reg <= pk_hi_reg - tcp_reg;
            if (measured_value < tcp_reg) begin
              first_reg <= 1'b0;
              if (first_reg && !atsp_reg && !ctrl_reg[`ATS_C_LOW_CUTBACK_AUTO])
                low_cutback_reg <= cb_floor(ovs_reg, cb_min);
              if (cyc_reg == `ATS_CYCLES - 2'd1) begin
                per_reg <= secs_reg >> 1;
                p2p_reg <= pk_hi_reg - pk_lo_reg;
                if (cool_en) begin
                  state_reg   <= S_EXTRA;
                  heat_on     <= 1'b1;
                  cool_on     <= 1'b0;
                end else begin
                  state_reg <= S_DONE;
                  heat_on   <= 1'b0;
                  rcg_reg   <= `ATS_RCG_ONE;
                  if (above_reg && !atsp_reg && !ctrl_reg[`ATS_C_HIGH_CUTBACK_AUTO])
                    high_cutback_reg <= cb_floor(tcp_reg - pk_lo_reg, cb_min);
                end
              end else begin
                cyc_reg   <= cyc_reg + 2'd1;
                state_reg <= S_OSC_HI;
                heat_on   <= 1'b1;
                cool_on   <= 1'b0;
              end
            end
          end
          S_EXTRA: begin
            if (measured_value >= tcp_reg) begin
              state_reg   <= S_NAT;
              heat_on     <= 1'b0;
              sec_cnt_reg <= 8'h00;
            end
          end
          S_NAT: begin
            if (sec_cnt_reg >= SETTLE) begin
              state_reg <= S_DONE;
              if (rcg_in_reg < `ATS_RCG_MIN || rcg_in_reg > `ATS_RCG_MAX) begin
                tune_fail <= 1'b1;
                rcg_reg   <= (rcg_in_reg < `ATS_RCG_MIN) ? `ATS_RCG_MIN : `ATS_RCG_MAX;
              end else begin
                rcg_reg <= rcg_in_reg;
              end
            end
          end
          S_DONE: begin
            state_reg <= S_IDLE;
            heat_on   <= 1'b0;
            cool_on   <= 1'b0;
            if (atsp_reg) begin
              low_cutback_reg <= cb_floor(low_cutback_reg, cb_min);
              high_cutback_reg <= cb_floor(high_cutback_reg, cb_min);
            end else if (!cool_en && !above_reg && !ctrl_reg[`ATS_C_HIGH_CUTBACK_AUTO]) begin
              high_cutback_reg <= low_cutback_reg;
            end else if (!cool_en && above_reg && !ctrl_reg[`ATS_C_LOW_CUTBACK_AUTO]) begin
              low_cutback_reg <= high_cutback_reg;
            end else if (cool_en && !ctrl_reg[`ATS_C_HIGH_CUTBACK_AUTO]) begin
              high_cutback_reg <= cb_floor(mulq8(low_cutback_reg, rcg_reg), cb_min);
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Fixed-point product with 8 fraction bits, saturated
  function [15:0] mulq8;
    input [15:0] a;
    input [15:0] g;
    reg [31:0] p;
    begin
      p = a * g;
      mulq8 = (p[31:24] != 8'h00) ? 16'hFFFF : p[23:8];
    end
  endfunction

  // Wishbone slave: one-cycle ack, word index on adr[5:2]
  wire       wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [3:0] idx    = wb_adr_i[5:2];
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h00000000;
      ctrl_reg   <= 16'h0000;
      sp_reg     <= 16'h0000;
      rhi_reg    <= 16'h0000;
      rlo_reg    <= 16'h0000;
      pb_reg     <= 16'h0000;
      rcg_in_reg <= `ATS_RCG_ONE;
    end else if (clk_en) begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_sel_i[1]) begin
        case (idx)
          `ATS_WB_CTRL:  ctrl_reg   <= wb_dat_i[15:0];
          `ATS_WB_SP:    sp_reg     <= wb_dat_i[15:0];
          `ATS_WB_RHI:   rhi_reg    <= wb_dat_i[15:0];
          `ATS_WB_RLO:   rlo_reg    <= wb_dat_i[15:0];
          `ATS_WB_PB:    pb_reg     <= wb_dat_i[15:0];
          `ATS_WB_RCGIN: rcg_in_reg <= wb_dat_i[15:0];
          default: begin
          end
        endcase
      end
      if (wb_req && !wb_we_i) begin
        case (idx)
          `ATS_WB_CTRL:   wb_dat_o <= {16'h0000, ctrl_reg};
          `ATS_WB_STAT:   wb_dat_o <= {24'h000000, tune_fail, cool_on, heat_on,
                                       output_frozen, state_reg};
          `ATS_WB_SP:     wb_dat_o <= {16'h0000, sp_reg};
          `ATS_WB_RHI:    wb_dat_o <= {16'h0000, rhi_reg};
          `ATS_WB_RLO:    wb_dat_o <= {16'h0000, rlo_reg};
          `ATS_WB_PB:     wb_dat_o <= {16'h0000, pb_reg};
          `ATS_WB_LOW_CUTBACK:   wb_dat_o <= {16'h0000, low_cutback_reg};
          `ATS_WB_HIGH_CUTBACK:   wb_dat_o <= {16'h0000, high_cutback_reg};
          `ATS_WB_RCG:    wb_dat_o <= {16'h0000, rcg_reg};
          `ATS_WB_PERIOD: wb_dat_o <= {16'h0000, per_reg};
          `ATS_WB_P2P:    wb_dat_o <= {16'h0000, p2p_reg};
          `ATS_WB_TCP:    wb_dat_o <= {16'h0000, tcp_reg};
          `ATS_WB_RCGIN:  wb_dat_o <= {16'h0000, rcg_in_reg};
          default:        wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // ats_autotune_sequencer
`default_nettype wire

/* design/ats_map.vh */
// Constant map for the autotune sequencer
`ifndef ATS_MAP_VH
`define ATS_MAP_VH
`define ATS_TICK_HZ       32'd250000000
`define ATS_SETTLE_S      8'd60
`define ATS_CYCLES        2'd2
`define ATS_RCG_ONE       16'h0100
`define ATS_RCG_MIN       16'h001A
`define ATS_RCG_MAX       16'h0A00
`define ATS_TOL_PCT_NUM   32'd3
`define ATS_TOL_PCT_DEN   32'd1000
`define ATS_TOL_ENG       16'h0001
`define ATS_CB_MIN_NUM    32'd16
`define ATS_CB_MIN_DEN    32'd10
`define ATS_WB_CTRL       4'h0
`define ATS_WB_STAT       4'h1
`define ATS_WB_SP         4'h2
`define ATS_WB_RHI        4'h3
`define ATS_WB_RLO        4'h4
`define ATS_WB_PB         4'h5
`define ATS_WB_LOW_CUTBACK       4'h6
`define ATS_WB_HIGH_CUTBACK       4'h7
`define ATS_WB_RCG        4'h8
`define ATS_WB_PERIOD     4'h9
`define ATS_WB_P2P        4'hA
`define ATS_WB_TCP        4'hB
`define ATS_WB_RCGIN      4'hC
`define ATS_C_START       0
`define ATS_C_COOL        1
`define ATS_C_ENG         2
`define ATS_C_LOW_CUTBACK_AUTO   3
`define ATS_C_HIGH_CUTBACK_AUTO   4
`endif
